/* File: include/audio_clock_ratio_detector_map.vh */
// Purpose: Offsets, field positions, reset values and timing counts of the clock ratio detector.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef AUDIO_CLOCK_RATIO_DETECTOR_MAP_VH
`define AUDIO_CLOCK_RATIO_DETECTOR_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_RATE_AND_RATIO 8'h5B
`define ADDR_BIT_RATIO_HIGH 8'h5C
`define ADDR_BIT_RATIO_LOW 8'h5D
`define ADDR_CLOCK_STATUS 8'h5E

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define RATE_CLASS_LSB 4
`define RATE_CLASS_MSB 6
`define RATIO_CODE_LSB 0
`define RATIO_CODE_MSB 3
`define RESERVED_BIT 7
`define FLAG_MCLK_HALTED 6
`define FLAG_LOOP_UNLOCKED 5
`define FLAG_FRAME_BIT_MISSING 4
`define FLAG_COMBINATION 3
`define FLAG_MCLK_INVALID 2
`define FLAG_BCLK_INVALID 1
`define FLAG_RATE_INVALID 0
`define REG_RESET 8'h00

// ----------------------------------------
// Rate class codes
// ----------------------------------------
`define RATE_ERROR 3'h0
`define RATE_8K 3'h1
`define RATE_16K 3'h2
`define RATE_32_48K 3'h3
`define RATE_88_96K 3'h4
`define RATE_176_192K 3'h5
`define RATE_384K 3'h6

// ----------------------------------------
// Timing: system clock and frame period windows in clk_i cycles
// ----------------------------------------
`define CLK_HZ 200000000
`define MCLK_MAX_HZ 50000000
`define MCLK_MAX_DIV (`CLK_HZ / `MCLK_MAX_HZ)
`define FRAME_8K_MIN 16'd22500
`define FRAME_8K_MAX 16'd27500
`define FRAME_16K_MIN 16'd11250
`define FRAME_16K_MAX 16'd13750
`define FRAME_48K_MIN 16'd4000
`define FRAME_48K_MAX 16'd6500
`define FRAME_96K_MIN 16'd2000
`define FRAME_96K_MAX 16'd2400
`define FRAME_192K_MIN 16'd1000
`define FRAME_192K_MAX 16'd1200
`define FRAME_384K_MIN 16'd480
`define FRAME_384K_MAX 16'd560
`define MCLK_HALT_CYC 11'd1024
`define BCLK_MISS_CYC 11'd2047
`define BCLK_RATIO_MIN 9'd32
`define BCLK_RATIO_MAX 9'd256
`define MIN_CODE_NO_LOOP 4'h4

`endif

/* File: hw/clk_edge_sync.v */
// Purpose: Two-flop synchroniser for a clock pin with edge detection.
// Assumes: Pin toggles slower than half of clk_i.
// Notes: First flop feeds only the second flop.
`timescale 1ns/1ps
module clk_edge_sync (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output wire level_o,
  output wire rise_o,
  output wire edge_o
);
  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign edge_o = sync_q ^ prev_q;
endmodule // clk_edge_sync

/* File: hw/audio_clock_ratio_detector.v */
// Purpose: Measures serial audio clocks and reports rate class, master ratio, bit ratio and clock status.
// Assumes: mclk_i, bclk_i, lrclk_i are pins; loop_enable_i and loop_locked_i come from clk_i logic.
// Notes: Registers reached through a plain address, write strobe and read data port.
//
// Overview of operation
// - Report 3-bit sample rate class, read-only
// - Report 4-bit master ratio code, zero is error
// - Flag error when ratio misfits detected rate
// - Without loop, low master ratio is error
// - Bit ratio MSB in bit 0, rest reserved storage
// - Count bit clocks per frame, low byte
// - Bit ratio unreliable at one per frame
// - Rate and ratio fields zero after reset
// - Status bit 6 flags halted master clock
// - Status bit 5 flags unlocked or disabled loop
// - Status bit 4 when frame and bit missing
// - Bit 1 flags unstable or out-of-range bit ratio
`timescale 1ns/1ps
`include "audio_clock_ratio_detector_map.vh"
module audio_clock_ratio_detector (
  input wire clk_i,
  input wire rst_i,
  input wire mclk_i,
  input wire bclk_i,
  input wire lrclk_i,
  input wire loop_enable_i,
  input wire loop_locked_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire mclk_rise;
  wire bclk_rise;
  wire bclk_level;
  wire bclk_edge;
  wire lrclk_rise;
  wire lrclk_level;
  wire lrclk_edge;

  clk_edge_sync u_mclk_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(mclk_i),
    .level_o(),
    .rise_o(mclk_rise),
    .edge_o()
  );

  clk_edge_sync u_bclk_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(bclk_i),
    .level_o(bclk_level),
    .rise_o(bclk_rise),
    .edge_o(bclk_edge)
  );

  clk_edge_sync u_lrclk_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(lrclk_i),
    .level_o(lrclk_level),
    .rise_o(lrclk_rise),
    .edge_o(lrclk_edge)
  );

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function near;
    input [11:0] n;
    input [11:0] r;
    begin
      near = (n + 12'h001 >= r) && (n <= r + 12'h001);
    end
  endfunction

  // Sampled master edges may be one off per frame, so each ratio has a window of one count either side
  function [3:0] ratio_code;
    input [11:0] n;
    begin
      if (near(n, 12'd32)) ratio_code = 4'h1;
      else if (near(n, 12'd48)) ratio_code = 4'h2;
      else if (near(n, 12'd64)) ratio_code = 4'h3;
      else if (near(n, 12'd128)) ratio_code = 4'h4;
      else if (near(n, 12'd192)) ratio_code = 4'h5;
      else if (near(n, 12'd256)) ratio_code = 4'h6;
      else if (near(n, 12'd384)) ratio_code = 4'h7;
      else if (near(n, 12'd512)) ratio_code = 4'h8;
      else if (near(n, 12'd768)) ratio_code = 4'h9;
      else if (near(n, 12'd1024)) ratio_code = 4'hA;
      else if (near(n, 12'd1152)) ratio_code = 4'hB;
      else if (near(n, 12'd1536)) ratio_code = 4'hC;
      else if (near(n, 12'd2048)) ratio_code = 4'hD;
      else if (near(n, 12'd3072)) ratio_code = 4'hE;
      else ratio_code = 4'h0;
    end
  endfunction

  function [2:0] rate_class;
    input [15:0] f;
    begin
      if (f >= `FRAME_8K_MIN && f <= `FRAME_8K_MAX) rate_class = `RATE_8K;
      else if (f >= `FRAME_16K_MIN && f <= `FRAME_16K_MAX) rate_class = `RATE_16K;
      else if (f >= `FRAME_48K_MIN && f <= `FRAME_48K_MAX) rate_class = `RATE_32_48K;
      else if (f >= `FRAME_96K_MIN && f <= `FRAME_96K_MAX) rate_class = `RATE_88_96K;
      else if (f >= `FRAME_192K_MIN && f <= `FRAME_192K_MAX) rate_class = `RATE_176_192K;
      else if (f >= `FRAME_384K_MIN && f <= `FRAME_384K_MAX) rate_class = `RATE_384K;
      else rate_class = `RATE_ERROR;
    end
  endfunction

  // ----------------------------------------
  // Per-frame counters
  // ----------------------------------------
  reg armed_q;
  reg [15:0] frame_cnt_q;
  reg [11:0] mclk_cnt_q;
  reg [8:0] bclk_cnt_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      frame_cnt_q <= 16'h0000;
      mclk_cnt_q <= 12'h000;
      bclk_cnt_q <= 9'h000;
    end else if (lrclk_rise) begin
      armed_q <= 1'b1;
      frame_cnt_q <= 16'h0001;
      mclk_cnt_q <= {11'h000, mclk_rise};
      bclk_cnt_q <= {8'h00, bclk_rise};
    end else begin
      if (frame_cnt_q != 16'hFFFF) frame_cnt_q <= frame_cnt_q + 16'h0001;
      if (mclk_rise && mclk_cnt_q != 12'hFFF) mclk_cnt_q <= mclk_cnt_q + 12'h001;
      if (bclk_rise && bclk_cnt_q != 9'h1FF) bclk_cnt_q <= bclk_cnt_q + 9'h001;
    end
  end

  // ----------------------------------------
  // Frame results
  // ----------------------------------------
  // The first frame after reset is partial, so only armed frames are latched
  reg [2:0] rate_q;
  reg [3:0] ratio_q;
  reg [8:0] bit_ratio_q;
  reg bit_stable_q;
  reg fast_mclk_q;
  reg [10:0] mclk_idle_q;
  wire mclk_halted = (mclk_idle_q == `MCLK_HALT_CYC);
  wire frame_done = lrclk_rise & armed_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      rate_q <= `RATE_ERROR;
      ratio_q <= 4'h0;
      bit_ratio_q <= 9'h000;
      bit_stable_q <= 1'b0;
      fast_mclk_q <= 1'b0;
    end else if (mclk_halted) begin
      ratio_q <= 4'h0;
    end else if (frame_done) begin
      rate_q <= rate_class(frame_cnt_q);
      ratio_q <= ratio_code(mclk_cnt_q);
      bit_ratio_q <= bclk_cnt_q;
      bit_stable_q <= (bclk_cnt_q == bit_ratio_q);
      // Master rate at or above the limit: one master edge every four clk_i cycles or faster
      fast_mclk_q <= ({2'b00, mclk_cnt_q, 2'b00} >= frame_cnt_q);
    end
  end

  // ----------------------------------------
  // Clock presence watchdogs
  // ----------------------------------------
  reg [10:0] frame_idle_q;
  wire both_missing = (frame_idle_q == `BCLK_MISS_CYC);

  always @(posedge clk_i) begin
    if (rst_i) begin
      mclk_idle_q <= 11'h000;
      frame_idle_q <= 11'h000;
    end else begin
      if (mclk_rise) mclk_idle_q <= 11'h000;
      else if (!mclk_halted) mclk_idle_q <= mclk_idle_q + 11'h001;
      // Either clock toggling or held high counts as present
      if (bclk_edge || lrclk_edge || bclk_level || lrclk_level) frame_idle_q <= 11'h000;
      else if (!both_missing) frame_idle_q <= frame_idle_q + 11'h001;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  wire loop_unlocked = ~loop_enable_i | ~loop_locked_i;
  wire rate_invalid = (rate_q == `RATE_ERROR);
  wire mclk_invalid = (ratio_q == 4'h0) | mclk_halted;
  wire bclk_invalid = ~bit_stable_q | (bit_ratio_q < `BCLK_RATIO_MIN) | (bit_ratio_q > `BCLK_RATIO_MAX);
  wire low_ratio = ~loop_enable_i & (ratio_q < `MIN_CODE_NO_LOOP);
  wire combo_error = rate_invalid | mclk_invalid | fast_mclk_q | low_ratio;

  wire [6:0] flags;
  assign flags[`FLAG_MCLK_HALTED] = mclk_halted;
  assign flags[`FLAG_LOOP_UNLOCKED] = loop_unlocked;
  assign flags[`FLAG_FRAME_BIT_MISSING] = both_missing;
  assign flags[`FLAG_COMBINATION] = combo_error;
  assign flags[`FLAG_MCLK_INVALID] = mclk_invalid;
  assign flags[`FLAG_BCLK_INVALID] = bclk_invalid;
  assign flags[`FLAG_RATE_INVALID] = rate_invalid;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  reg res_rate_q;
  reg [6:0] res_high_q;
  reg res_status_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  always @(posedge clk_i) begin
    if (rst_i) begin
      res_rate_q <= 1'b0;
      res_high_q <= 7'h00;
      res_status_q <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ADDR_RATE_AND_RATIO) res_rate_q <= reg_wdata_i[`RESERVED_BIT];
      if (reg_addr_i == `ADDR_BIT_RATIO_HIGH) res_high_q <= reg_wdata_i[7:1];
      if (reg_addr_i == `ADDR_CLOCK_STATUS) res_status_q <= reg_wdata_i[`RESERVED_BIT];
    end
  end

  // Measured fields ignore writes; only reserved storage bits take write data
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `ADDR_RATE_AND_RATIO: rdata_d = {res_rate_q, rate_q, ratio_q};
      `ADDR_BIT_RATIO_HIGH: rdata_d = {res_high_q, bit_ratio_q[8]};
      `ADDR_BIT_RATIO_LOW: rdata_d = bit_ratio_q[7:0];
      `ADDR_CLOCK_STATUS: rdata_d = {res_status_q, flags};
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) rdata_q <= `REG_RESET;
    else rdata_q <= rdata_d;
  end

  assign reg_rdata_o = rdata_q;

endmodule // audio_clock_ratio_detector

/* File: verification/audio_host_model.sv */
// Purpose: Audio host model driving the master, bit and frame clocks.
// Assumes: The bench sets the rates before raising the run inputs.
// Notes: Bit and frame clocks rest low while frame_run_i is low, as a tied-low host would.
`timescale 1ns/1ps
module audio_host_model (
  input wire mclk_run_i,
  input wire frame_run_i,
  input wire [15:0] mclk_half_i,
  input wire [9:0] bits_i,
  output logic mclk_o,
  output logic bclk_o,
  output logic lrclk_o
);
  // ------------------------------
  // Clock generation
  // ------------------------------
  // Edges sit 1 ns off the system grid so sampling never races
  initial begin
    mclk_o = 1'b0;
    #1;
    forever begin
      #(mclk_half_i);
      mclk_o = mclk_run_i & ~mclk_o;
    end
  end
  // A stop request takes effect at the end of the current frame
  initial begin
    bclk_o = 1'b0;
    lrclk_o = 1'b0;
    #1;
    forever begin
      if (frame_run_i) begin
        for (int i = 0; i < bits_i; i++) begin
          lrclk_o = (i < bits_i / 2);
          #80 bclk_o = 1'b1;
          #80 bclk_o = 1'b0;
        end
      end else begin
        lrclk_o = 1'b0;
        #80;
      end
    end
  end
endmodule // audio_host_model

/* File: verification/audio_clock_ratio_detector_asserts.sv */
// Purpose: Port checks of the clock ratio detector.
// Assumes: Read data shows the address of the previous cycle.
// Notes: Measured values are left to the bench.
`timescale 1ns/1ps
`include "audio_clock_ratio_detector_map.vh"
module audio_clock_ratio_detector_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire mclk_i,
  input wire bclk_i,
  input wire lrclk_i,
  input wire loop_enable_i,
  input wire loop_locked_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o
);
  // ------------------------------
  // Checks
  // ------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Pin count runs ahead of the synced one, hence the wide margins
  logic [10:0] idle_q;
  logic mclk_q;
  wire st = reg_addr_i == `ADDR_CLOCK_STATUS;
  wire unl = !(loop_enable_i && loop_locked_i);
  always @(posedge clk_i) begin
    mclk_q <= mclk_i;
    if (rst_i || (mclk_i && !mclk_q)) begin
      idle_q <= 11'h000;
    end else if (idle_q != 11'h7FF) begin
      idle_q <= idle_q + 11'h001;
    end
  end
  property p_rst;
    disable iff (1'b0) rst_i |=> reg_rdata_o == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("read data not cleared");
  property p_loop;
    st |=> reg_rdata_o[5] == $past(unl);
  endproperty
  a_loop: assert property (p_loop) else $error("loop flag wrong");
  property p_halt;
    st && idle_q > 11'h44C |=> reg_rdata_o[6];
  endproperty
  a_halt: assert property (p_halt) else $error("halt not flagged");
  property p_run;
    st && idle_q < 11'h384 && $past(idle_q, 8) < 11'h384 |=> !reg_rdata_o[6];
  endproperty
  a_run: assert property (p_run) else $error("halt flagged while running");
  property p_miss;
    bclk_i[*5] ##0 st |=> !reg_rdata_o[4];
  endproperty
  a_miss: assert property (p_miss) else $error("missing flag with bit clock high");
  property p_comb;
    st |=> reg_rdata_o[3] || !(reg_rdata_o[0] || reg_rdata_o[2]);
  endproperty
  a_comb: assert property (p_comb) else $error("combination flag not raised");
  property p_res5e;
    reg_wr_i && st ##1 st && !reg_wr_i |=> reg_rdata_o[7] == $past(reg_wdata_i[7], 2);
  endproperty
  a_res5e: assert property (p_res5e) else $error("status bit 7 not stored");
  sequence s_wr5c;
    reg_wr_i && reg_addr_i == `ADDR_BIT_RATIO_HIGH ##1 reg_addr_i == `ADDR_BIT_RATIO_HIGH && !reg_wr_i;
  endsequence
  property p_res5c;
    s_wr5c |=> reg_rdata_o[7:1] == $past(reg_wdata_i[7:1], 2);
  endproperty
  a_res5c: assert property (p_res5c) else $error("high ratio spare bits not stored");
  c_halt: cover property (st ##1 reg_rdata_o[6]);
  c_miss: cover property (st ##1 reg_rdata_o[4]);
  c_err: cover property (st ##1 reg_rdata_o[3]);
endmodule // audio_clock_ratio_detector_asserts
bind audio_clock_ratio_detector audio_clock_ratio_detector_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .mclk_i(mclk_i), .bclk_i(bclk_i), .lrclk_i(lrclk_i), .loop_enable_i(loop_enable_i),
  .loop_locked_i(loop_locked_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o));

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench of the clock ratio detector.
// Assumes: Inputs change on the falling clock edge.
// Notes: Each table row runs four frames so two equal frames are seen.
`timescale 1ns/1ps
`include "audio_clock_ratio_detector_map.vh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic loop_en = 1'b0;
  logic loop_lock = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic mclk_run = 1'b0;
  logic frame_run = 1'b0;
  logic [15:0] half = 16'h0014;
  logic [9:0] bits = 10'h040;
  logic [71:0] e;
  wire mclk;
  wire bclk;
  wire lrclk;
  wire [7:0] rdata;
  int err_count = 0;
  int check_count = 0;
  // Row: bits, half period, loop enable, expected 0x5B, 0x5C, 0x5D, 0x5E
  logic [71:0] tbl [5] = '{72'h0040_0014_01_46_00_40_00, 72'h0020_0028_01_53_00_20_00,
    72'h0100_0014_01_0A_01_00_09, 72'h0040_0050_00_43_00_40_28, 72'h0080_0014_01_38_00_80_00};
  // ------------------------------
  // Harness
  // ------------------------------
  audio_host_model u_host (.mclk_run_i(mclk_run), .frame_run_i(frame_run), .mclk_half_i(half),
    .bits_i(bits), .mclk_o(mclk), .bclk_o(bclk), .lrclk_o(lrclk));
  audio_clock_ratio_detector u_dut (.clk_i(clk_i), .rst_i(rst_i), .mclk_i(mclk), .bclk_i(bclk),
    .lrclk_i(lrclk), .loop_enable_i(loop_en), .loop_locked_i(loop_lock), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wr = 1'b1;
    wdata = d;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  // Address is left in place so the checker keeps watching that register
  task automatic read_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    @(negedge clk_i);
    addr = a;
    @(negedge clk_i);
    check($sformatf("reg %h", a), rdata & m, x);
  endtask
  task automatic complete_run;
    $display("Checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    complete_run();
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      logic [7:0] a;
      logic [7:0] m;
      a = 8'h5B + 8'(i);
      m = (i == 3) ? 8'h80 : 8'hFF;
      read_chk(a, m, 8'h00);
      reg_write(a, 8'hFF);
      read_chk(a, m, 8'(32'h80FE0080 >> (24 - 8 * i)));
      reg_write(a, 8'h00);
    end
    read_chk(8'h60, 8'hFF, 8'h00);
    for (int k = 0; k < 4; k++) begin
      loop_en = k[0];
      loop_lock = k[1];
      read_chk(`ADDR_CLOCK_STATUS, 8'h20, (k == 3) ? 8'h00 : 8'h20);
    end
    mclk_run = 1'b1;
    frame_run = 1'b1;
    for (int i = 0; i < 5; i++) begin
      e = tbl[i];
      bits = e[65:56];
      half = e[55:40];
      loop_en = e[32];
      repeat (128 * bits + 300) @(posedge clk_i);
      read_chk(`ADDR_RATE_AND_RATIO, 8'hFF, e[31:24]);
      read_chk(`ADDR_BIT_RATIO_HIGH, 8'hFF, e[23:16]);
      read_chk(`ADDR_BIT_RATIO_LOW, 8'hFF, e[15:8]);
      read_chk(`ADDR_CLOCK_STATUS, 8'h7F, e[7:0]);
    end
    mclk_run = 1'b0;
    repeat (1200) @(negedge clk_i);
    read_chk(`ADDR_CLOCK_STATUS, 8'h4C, 8'h4C);
    read_chk(`ADDR_RATE_AND_RATIO, 8'h0F, 8'h00);
    mclk_run = 1'b1;
    repeat (200) @(negedge clk_i);
    read_chk(`ADDR_CLOCK_STATUS, 8'h40, 8'h00);
    frame_run = 1'b0;
    repeat (6700) @(negedge clk_i);
    read_chk(`ADDR_CLOCK_STATUS, 8'h10, 8'h10);
    frame_run = 1'b1;
    repeat (300) @(negedge clk_i);
    read_chk(`ADDR_CLOCK_STATUS, 8'h10, 8'h00);
    complete_run();
  end
endmodule // tb_top
